/* logic/ivn_pkg.sv */
// Constants and types for the interrupt vector number register bank.
// Assumes one clock domain and a 32-bit AXI4-Lite register bus.
package ivn_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bank shape
  localparam int REG_N    = 8;
  localparam int DATA_W   = 16;
  localparam int VEC_W    = 7;
  localparam int IDX_W    = 3;
  localparam int ADDR_W   = 12;
  localparam int AXI_DW   = 32;
  localparam int LANE_W   = 8;

  // Field positions inside every vector register
  localparam int HI_LSB   = 8;
  localparam int LO_LSB   = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Byte offsets of the registers on the bus
  localparam logic [ADDR_W-1:0] OFF_SERIAL_TX    = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_FREERUN_CC   = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_FREERUN_OVF  = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_UNIT0_AB     = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_UNIT0_CD     = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_UNIT0_OVF    = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_UNIT1_AB     = 12'h018;
  localparam logic [ADDR_W-1:0] OFF_UNIT1_OU     = 12'h01C;
  localparam logic [ADDR_W-1:0] OFF_LAST         = OFF_UNIT1_OU;
  localparam int                WORD_LSB         = 2;

  // Register indices (offset divided by four)
  localparam logic [IDX_W-1:0] IDX_SERIAL_TX   = 3'h0;
  localparam logic [IDX_W-1:0] IDX_FREERUN_CC  = 3'h1;
  localparam logic [IDX_W-1:0] IDX_FREERUN_OVF = 3'h2;
  localparam logic [IDX_W-1:0] IDX_UNIT0_AB    = 3'h3;
  localparam logic [IDX_W-1:0] IDX_UNIT0_CD    = 3'h4;
  localparam logic [IDX_W-1:0] IDX_UNIT0_OVF   = 3'h5;
  localparam logic [IDX_W-1:0] IDX_UNIT1_AB    = 3'h6;
  localparam logic [IDX_W-1:0] IDX_UNIT1_OU    = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Reset value and writable bits; reserved bits are never stored
  localparam logic [DATA_W-1:0] RESET_VAL  = 16'h0000;
  localparam logic [DATA_W-1:0] MASK_PAIR  = 16'h7F7F;
  localparam logic [DATA_W-1:0] MASK_HIGH  = 16'h7F00;
  localparam logic [REG_N-1:0][DATA_W-1:0] WR_MASK = {
    MASK_PAIR, MASK_PAIR, MASK_HIGH, MASK_PAIR,
    MASK_PAIR, MASK_HIGH, MASK_PAIR, MASK_PAIR};

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt sources whose vector the bank supplies
  typedef enum logic [3:0] {
    SRC_TX_EMPTY, SRC_TX_END, SRC_CAPTURE, SRC_COMPARE, SRC_FR_OVERFLOW,
    SRC_U0_REG_A, SRC_U0_REG_B, SRC_U0_REG_C, SRC_U0_REG_D,
    SRC_U0_OVERFLOW, SRC_U1_REG_A, SRC_U1_REG_B, SRC_U1_OVERFLOW,
    SRC_U1_UNDERFLOW
  } ivn_src_t;

endpackage

/* logic/ivn_vector_sel.sv */
// Vector number lookup for an accepted interrupt source.
// Assumes accept pulses come from logic on the same clock.
`timescale 1ns/1ps
module ivn_vector_sel
  import ivn_pkg::*;
(
  input  wire logic                          aclk,        // Bus clock
  input  wire logic                          aresetn,     // Sync reset, low
  input  wire logic [REG_N-1:0][DATA_W-1:0]  vec_bank,    // Register contents
  input  wire logic                          accept,      // Source accepted
  input  wire ivn_src_t                      source,      // Accepted source
  output logic      [VEC_W-1:0]              vector_num,  // Supplied vector
  output logic                               vector_valid,// One-cycle strobe
  output logic                               vector_err   // Unknown source
);

  logic [IDX_W-1:0] sel_idx;
  logic             sel_high;
  logic             sel_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Source to register and half
  always_comb
  begin
    sel_idx  = IDX_SERIAL_TX;
    sel_high = 1'b1;
    sel_ok   = 1'b1;
    case (source)
      SRC_TX_EMPTY:     sel_idx = IDX_SERIAL_TX;
      SRC_TX_END:
      begin
        sel_idx  = IDX_SERIAL_TX;
        sel_high = 1'b0;
      end
      SRC_CAPTURE:      sel_idx = IDX_FREERUN_CC;
      SRC_COMPARE:
      begin
        sel_idx  = IDX_FREERUN_CC;
        sel_high = 1'b0;
      end
      SRC_FR_OVERFLOW:  sel_idx = IDX_FREERUN_OVF;
      SRC_U0_REG_A:     sel_idx = IDX_UNIT0_AB;
      SRC_U0_REG_B:
      begin
        sel_idx  = IDX_UNIT0_AB;
        sel_high = 1'b0;
      end
      SRC_U0_REG_C:     sel_idx = IDX_UNIT0_CD;
      SRC_U0_REG_D:
      begin
        sel_idx  = IDX_UNIT0_CD;
        sel_high = 1'b0;
      end
      SRC_U0_OVERFLOW:  sel_idx = IDX_UNIT0_OVF;
      SRC_U1_REG_A:     sel_idx = IDX_UNIT1_AB;
      SRC_U1_REG_B:
      begin
        sel_idx  = IDX_UNIT1_AB;
        sel_high = 1'b0;
      end
      SRC_U1_OVERFLOW:  sel_idx = IDX_UNIT1_OU;
      SRC_U1_UNDERFLOW:
      begin
        sel_idx  = IDX_UNIT1_OU;
        sel_high = 1'b0;
      end
      default:          sel_ok = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // supply current vector
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      vector_num   <= '0;
      vector_valid <= 1'b0;
      vector_err   <= 1'b0;
    end
    else
    begin
      vector_valid <= accept && sel_ok;
      vector_err   <= accept && !sel_ok;
      if (accept)
      begin
        if (!sel_ok)
          vector_num <= '0;
        else if (sel_high)
          vector_num <= vec_bank[sel_idx][HI_LSB +: VEC_W];
        else
          vector_num <= vec_bank[sel_idx][LO_LSB +: VEC_W];
      end
    end
  end

endmodule

/* logic/ivn_regs.sv */
// Interrupt vector number register bank with an AXI4-Lite slave port.
// Assumes one clock, a synchronous low reset and a single bus master.
//
// Contract
// - Each vector register is 16-bit read/write and resets to all zeros.
// - Standby entry or exit never clears a register; values are kept.
// - Bits 15 and 7 are reserved and always read as zero.
// - Each vector field is seven bits, 0 to 127, readable and writable.
// - Serial transmit register bits 14:8 hold the transmit-empty vector.
// - Serial transmit register bits 6:0 hold the transmit-end vector.
// - Free-running capture/compare register: capture 14:8, compare 6:0.
// - Free-running overflow register: vector 14:8, bits 15 and 7:0 zero.
// - Unit 0 register A vector in 14:8, register B vector in 6:0.
// - Unit 0 register C vector in 14:8, register D vector in 6:0.
// - Unit 0 counter overflow vector in 14:8, bits 15 and 7:0 zero.
// - Unit 1 register A vector in 14:8, register B vector in 6:0.
// - Unit 1 counter overflow vector in 14:8, underflow in 6:0.
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module ivn_regs
  import ivn_pkg::*;
(
  input  wire logic              aclk,          // Bus clock, 25 MHz
  input  wire logic              aresetn,       // Sync reset, active low
  // Write address channel
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,  // Write byte address
  input  wire logic              s_axi_awvalid, // Write address valid
  output logic                   s_axi_awready, // Write address ready
  // Write data channel
  input  wire logic [AXI_DW-1:0] s_axi_wdata,   // Write data
  input  wire logic [3:0]        s_axi_wstrb,   // Byte enables
  input  wire logic              s_axi_wvalid,  // Write data valid
  output logic                   s_axi_wready,  // Write data ready
  // Write response channel
  output logic [1:0]             s_axi_bresp,   // Write response
  output logic                   s_axi_bvalid,  // Write response valid
  input  wire logic              s_axi_bready,  // Write response ready
  // Read address channel
  input  wire logic [ADDR_W-1:0] s_axi_araddr,  // Read byte address
  input  wire logic              s_axi_arvalid, // Read address valid
  output logic                   s_axi_arready, // Read address ready
  // Read data channel
  output logic [AXI_DW-1:0]      s_axi_rdata,   // Read data
  output logic [1:0]             s_axi_rresp,   // Read response
  output logic                   s_axi_rvalid,  // Read data valid
  input  wire logic              s_axi_rready,  // Read data ready
  // Vector supply to the interrupt acceptance logic
  input  wire logic              irq_accept,    // Source accepted, pulse
  input  wire ivn_src_t          irq_source,    // Which source
  output logic [VEC_W-1:0]       vector_num,    // Vector for that source
  output logic                   vector_valid,  // Vector strobe
  output logic                   vector_err     // Source not in bank
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding shared by the read and write paths

  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr);
    return (addr >> WORD_LSB) <= (OFF_LAST >> WORD_LSB);
  endfunction

  function automatic logic [IDX_W-1:0] addr_index(
    input logic [ADDR_W-1:0] addr);
    return addr[WORD_LSB +: IDX_W];
  endfunction

  // Byte-lane merge; bits outside the writable mask are forced to zero
  function automatic logic [DATA_W-1:0] lane_merge(
    input logic [DATA_W-1:0] old_val,
    input logic [DATA_W-1:0] new_val,
    input logic [1:0]        strb,
    input logic [DATA_W-1:0] mask);
    logic [DATA_W-1:0] lanes;
    lanes = {{LANE_W{strb[1]}}, {LANE_W{strb[0]}}};
    return ((old_val & ~lanes) | (new_val & lanes)) & mask;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [REG_N-1:0][DATA_W-1:0] vec_bank;

  logic [ADDR_W-1:0] aw_addr_q;
  logic              aw_held;
  logic [DATA_W-1:0] w_data_q;
  logic [1:0]        w_strb_q;
  logic              w_held;

  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_fire;
  logic wr_hit;
  logic [IDX_W-1:0] wr_idx;

  logic next_aw_held;
  logic next_w_held;
  logic next_bvalid;
  logic next_rvalid;

  ////////////////////////////////////////////////////////////////////////////
  // Handshake terms

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take  = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  // A write is performed once both halves are held and no response waits
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_hit  = addr_hit(aw_addr_q);
  assign wr_idx  = addr_index(aw_addr_q);

  always_comb
  begin
    next_aw_held = (aw_held && !wr_fire) || aw_take;
    next_w_held  = (w_held && !wr_fire) || w_take;
    next_bvalid  = (s_axi_bvalid && !s_axi_bready) || wr_fire;
    next_rvalid  = (s_axi_rvalid && !s_axi_rready) || ar_take;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write address capture

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held   <= 1'b0;
      aw_addr_q <= '0;
    end
    else
    begin
      aw_held <= next_aw_held;
      if (aw_take)
        aw_addr_q <= s_axi_awaddr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write data capture; only the two low byte lanes carry register bits

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held   <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end
    else
    begin
      w_held <= next_w_held;
      if (w_take)
      begin
        w_data_q <= s_axi_wdata[DATA_W-1:0];
        w_strb_q <= s_axi_wstrb[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ready outputs; closed while a response waits so one write and
  // one read at most are ever in flight

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !next_aw_held && !next_bvalid;
      s_axi_wready  <= !next_w_held && !next_bvalid;
      s_axi_arready <= !next_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write response

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else
    begin
      s_axi_bvalid <= next_bvalid;
      if (wr_fire)
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_DECERR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage. Only the bus reset clears it: there is no standby
  // input at all, so a low-power entry cannot disturb programmed vectors.

  for (genvar g = 0; g < REG_N; g++)
  begin : g_reg
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        vec_bank[g] <= RESET_VAL;
      else if (wr_fire && wr_hit && wr_idx == IDX_W'(g))
        vec_bank[g] <= lane_merge(vec_bank[g], w_data_q, w_strb_q,
                                  WR_MASK[g]);
    end
  end

  // Field layouts below are fixed by WR_MASK and the lookup table:
  // transmit-empty high half
  // unit 0 A high, B low
  // unit 0 C high, D low
  // unit 1 A high, B low
  // reserved writes dropped, so software slips are harmless

  ////////////////////////////////////////////////////////////////////////////
  // Read path: answer one cycle after the address is taken

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end
    else
    begin
      s_axi_rvalid <= next_rvalid;
      if (ar_take)
      begin
        if (addr_hit(s_axi_araddr))
        begin
          s_axi_rdata <= {{(AXI_DW-DATA_W){1'b0}},
                          vec_bank[addr_index(s_axi_araddr)]};
          s_axi_rresp <= RESP_OKAY;
        end
        else
        begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_DECERR;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Vector supply; sees a write from the cycle after it lands

  ivn_vector_sel u_vector_sel (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .vec_bank     (vec_bank),
    .accept       (irq_accept),
    .source       (irq_source),
    .vector_num   (vector_num),
    .vector_valid (vector_valid),
    .vector_err   (vector_err)
  );

endmodule

/* bench/ivn_regs_assertions.sv */
// Assertions for the vector register bank, one clock domain.
// Bound into ivn_regs; sees only its ports.
`timescale 1ns/1ps
module ivn_regs_assertions
  import ivn_pkg::*;
(
  input wire logic              aclk,          // Clock
  input wire logic              aresetn,       // Reset
  input wire logic              s_axi_awvalid, // AW valid
  input wire logic              s_axi_awready, // AW ready
  input wire logic              s_axi_wvalid,  // W valid
  input wire logic              s_axi_wready,  // W ready
  input wire logic              s_axi_bvalid,  // B valid
  input wire logic [ADDR_W-1:0] s_axi_araddr,  // AR addr
  input wire logic              s_axi_arvalid, // AR valid
  input wire logic              s_axi_arready, // AR ready
  input wire logic [AXI_DW-1:0] s_axi_rdata,   // R data
  input wire logic [1:0]        s_axi_rresp,   // R resp
  input wire logic              s_axi_rvalid,  // R valid
  input wire logic              s_axi_rready,  // R ready
  input wire logic              irq_accept,    // Accept
  input wire ivn_src_t          irq_source,    // Source
  input wire logic [VEC_W-1:0]  vector_num,    // Vector
  input wire logic              vector_valid,  // Strobe
  input wire logic              vector_err     // Bad source
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Word index of the read in flight; byte lanes 1:0 are ignored
  logic [ADDR_W-1:0] rd_idx;
  always_ff @(posedge aclk)
    if (s_axi_arvalid && s_axi_arready)
      rd_idx <= s_axi_araddr >> WORD_LSB;
  //////////////////////////////////////////////////////////////////////////
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write got no response");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read got no data");
  a_read_once: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_resv_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:15] == 17'h0 && !s_axi_rdata[7])
    else $error("reserved bit read as one");
  a_single_low: assert property (
    s_axi_rvalid && (rd_idx == 12'h2 || rd_idx == 12'h5)
    |-> s_axi_rdata[7:0] == 8'h00) else $error("low byte not zero");
  a_unmapped_err: assert property (
    s_axi_rvalid && rd_idx > 12'h7
    |-> s_axi_rresp == RESP_DECERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_vec_strobe: assert property (
    irq_accept && irq_source <= SRC_U1_UNDERFLOW
    |=> vector_valid && !vector_err) else $error("no vector strobe");
  a_vec_unknown: assert property (
    irq_accept && irq_source > SRC_U1_UNDERFLOW
    |=> vector_err && !vector_valid && vector_num == 7'h00)
    else $error("unknown source not flagged");
endmodule

bind ivn_regs ivn_regs_assertions u_ivn_chk (.*);

/* bench/ivn_regs_bench.sv */
// Self-checking bench for the vector register bank.
// Drives AXI4-Lite and the accept port itself; 25 MHz clock.
`timescale 1ns/1ps
module ivn_regs_bench
  import ivn_pkg::*;
;
  logic aclk, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic irq_accept = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, vector_valid, vector_err;
  logic [ADDR_W-1:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [AXI_DW-1:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]        s_axi_wstrb = 4'h0;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rs;
  logic [VEC_W-1:0]  vector_num;
  ivn_src_t          irq_source = SRC_TX_EMPTY;
  int                n_fail = 0, checks = 0;
  int sreg [14] = '{0, 0, 1, 1, 2, 3, 3, 4, 4, 5, 6, 6, 7, 7};
  bit shi [14] = '{1, 0, 1, 0, 1, 1, 0, 1, 0, 1, 1, 0, 1, 0};
  ivn_regs dut (.*);
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Distinct vectors per register; one-field registers keep 7:0 zero
  function automatic logic [15:0] pat(input int i);
    logic [6:0] lo;
    lo = (i == 2 || i == 5) ? 7'h00 : 7'(16 * i + 9);
    return {1'b0, 7'(16 * i + 3), 1'b0, lo};
  endfunction
  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 99; i++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        return;
      end
    end
    check(32'h0, 32'h1);
    tally_and_finish();
  endtask
  task automatic rd_reg(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 99; i++)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        return;
      end
    end
    check(32'h0, 32'h1);
    tally_and_finish();
  endtask
  task automatic acc(input ivn_src_t s, input logic [6:0] e);
    @(posedge aclk);
    irq_accept <= 1'b1;
    irq_source <= s;
    @(posedge aclk);
    irq_accept <= 1'b0;
    #1;
    check(vector_num, e);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_zero;
    for (int i = 0; i < REG_N; i++)
    begin
      rd_reg(12'(4 * i));
      check(rd, 32'h0);
      check(rs, RESP_OKAY);
    end
    $display("done: reset values");
  endtask
  task automatic t_reserved;
    for (int i = 0; i < REG_N; i++)
    begin
      wr(12'(4 * i), 32'hFFFF_FFFF, 4'hF);
      rd_reg(12'(4 * i));
      check(rd, (i == 2 || i == 5) ? 32'h7F00 : 32'h7F7F);
    end
    acc(SRC_TX_EMPTY, 7'h7F);
    acc(SRC_U1_UNDERFLOW, 7'h7F);
    $display("done: reserved bits");
  endtask
  task automatic t_vectors;
    logic [15:0] w;
    logic [6:0]  e;
    for (int i = 0; i < REG_N; i++)
    begin
      wr(12'(4 * i), {16'h0, pat(i)}, 4'h3);
      check(rs, RESP_OKAY);
      rd_reg(12'(4 * i));
      check(rd, {16'h0, pat(i)});
    end
    // Accepts back to back, every source code including unknown ones
    @(posedge aclk);
    irq_accept <= 1'b1;
    irq_source <= SRC_TX_EMPTY;
    for (int s = 1; s <= 16; s++)
    begin
      @(posedge aclk);
      if (s < 16)
        irq_source <= ivn_src_t'(s);
      else
        irq_accept <= 1'b0;
      #1;
      e = 7'h00;
      if (s <= 14)
      begin
        w = pat(sreg[s - 1]);
        e = shi[s - 1] ? w[14:8] : w[6:0];
      end
      check(vector_valid, s <= 14);
      check(vector_err, s > 14);
      check(vector_num, e);
    end
    $display("done: vector supply");
  endtask
  task automatic t_bus_edges;
    wr(OFF_UNIT0_AB, 32'hFFFF_3344, 4'h1);
    wr(OFF_UNIT0_AB, 32'hFFFF_FFFF, 4'hC);
    rd_reg(OFF_UNIT0_AB + 12'h3);
    check(rd, {16'h0, pat(3) & 16'hFF00 | 16'h0044});
    acc(SRC_U0_REG_B, 7'h44);
    wr(12'h020, 32'hFFFF_FFFF, 4'hF);
    check(rs, RESP_DECERR);
    rd_reg(12'h020);
    check(rd, 32'h0);
    check(rs, RESP_DECERR);
    $display("done: strobes and unmapped");
  endtask
  task automatic t_keep;
    repeat (40) @(posedge aclk);
    rd_reg(OFF_UNIT1_OU);
    check(rd, {16'h0, pat(7)});
    do_reset();
    t_zero();
    $display("done: hold and reset");
  endtask
  initial
  begin
    do_reset();
    t_zero();
    t_reserved();
    t_vectors();
    t_bus_edges();
    t_keep();
    tally_and_finish();
  end
endmodule
